// *** rtl/branch_params.svh ***
// named constants of the program-flow unit: timing, opcodes, field positions
// assumes a 200 MHz core clock and 16-bit program addresses
`ifndef BRANCH_PARAMS_SVH
`define BRANCH_PARAMS_SVH

// timing, all figures in nanoseconds
`define CLK_PERIOD_NS      5
`define MC_TIME_NS         1000
`define NOP_TIME_NS        1000
`define FLOW_TIME_NS       2000

// widths
`define ADDR_W             16
`define PAGE_W             11
`define DIV_W              8
`define MCS_W              4

// opcodes with a fixed encoding
`define OPC_NO_OPERATION   8'h00
`define OPC_LONG_JUMP      8'h02
`define OPC_LONG_CALL      8'h12
`define OPC_SUB_RETURN     8'h22
`define OPC_INT_RETURN     8'h32
`define OPC_JUMP_ACC_ZERO  8'h60
`define OPC_JUMP_ACC_NZ    8'h70
`define OPC_TABLE_JUMP     8'h73
`define OPC_SHORT_JUMP     8'h80
`define OPC_CMP_ACC_IMM    8'hB4
`define OPC_CMP_ACC_DIR    8'hB5
`define OPC_DEC_DIRECT     8'hD5

// opcodes that carry a field in their low or high bits
`define PAGE_OPC_MASK      8'h1F
`define OPC_PAGE_JUMP      8'h01
`define OPC_PAGE_CALL      8'h11
`define REG_OPC_MASK       8'hF8
`define OPC_CMP_REG        8'hB8
`define OPC_DEC_REG        8'hD8
`define IND_OPC_MASK       8'hFE
`define OPC_CMP_IND        8'hB6
`define PAGE_HI_MSB        7
`define PAGE_HI_LSB        5

`endif

// *** rtl/branch_pkg.sv ***
// types shared by the program-flow unit and its helpers
// assumes branch_params.svh is on the include path
`default_nettype none
`include "branch_params.svh"

package branch_pkg;

  // instruction classes handled by the unit
  typedef enum logic [3:0] {
    KIND_NONE,
    KIND_NO_OPERATION,
    KIND_SHORT_REL,
    KIND_LONG_ABS,
    KIND_PAGE_JUMP,
    KIND_LONG_CALL,
    KIND_PAGE_CALL,
    KIND_SUB_RETURN,
    KIND_INT_RETURN,
    KIND_ACC_ZERO,
    KIND_ACC_NONZERO,
    KIND_DEC_REG,
    KIND_DEC_DIRECT,
    KIND_COMPARE,
    KIND_TABLE_JUMP
  } instr_kind_t;

  // sequencing states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PUSH_LO,
    ST_PUSH_HI,
    ST_POP_HI,
    ST_POP_LO,
    ST_CAP_HI,
    ST_CAP_LO,
    ST_WAIT
  } flow_state_t;

  // complete state of the unit
  typedef struct packed {
    flow_state_t         st;
    instr_kind_t         kind;
    logic [`DIV_W-1:0]   div;
    logic [`MCS_W-1:0]   mcs_left;
    logic [`ADDR_W-1:0]  target;
    logic [`ADDR_W-1:0]  ret_addr;
    logic                taken;
    logic                carry;
    logic [7:0]          dec_val;
    logic                in_intr;
    logic                busy;
    logic                done;
    logic                pc_load;
    logic [`ADDR_W-1:0]  pc_out;
    logic                push;
    logic                pop;
    logic [7:0]          wdata;
    logic                carry_we;
    logic                carry_out;
    logic                dec_we;
    logic [7:0]          dec_out;
    logic                intr_done;
  } flow_reg_t;

endpackage

`default_nettype wire

// *** rtl/branch_target_calc.sv ***
// destination address former for every jump, call and branch form
// assumes next_pc already points past the whole instruction
`default_nettype none
`include "branch_params.svh"

module branch_target_calc (
  // instruction
  input  wire branch_pkg::instr_kind_t kind,
  input  wire logic [7:0]              opcode,
  input  wire logic [7:0]              byte1,
  input  wire logic [7:0]              byte2,
  input  wire logic [`ADDR_W-1:0]      next_pc,
  // operands
  input  wire logic [7:0]              acc,
  input  wire logic [`ADDR_W-1:0]      data_pointer_register,
  // result
  output logic      [`ADDR_W-1:0]      target
);

  // signed offset added to the following address, wraps in 64K
  function automatic logic [`ADDR_W-1:0] rel_target(input logic [`ADDR_W-1:0] pc,
                                                    input logic [7:0] ofs);
    rel_target = pc + {{(`ADDR_W-8){ofs[7]}}, ofs};
  endfunction

  // pick the address form that the class carries
  always_comb begin
    unique case (kind)
      branch_pkg::KIND_SHORT_REL, branch_pkg::KIND_ACC_ZERO, branch_pkg::KIND_ACC_NONZERO,
      branch_pkg::KIND_DEC_REG:
        target = rel_target(next_pc, byte1);
      branch_pkg::KIND_DEC_DIRECT, branch_pkg::KIND_COMPARE:
        target = rel_target(next_pc, byte2);
      branch_pkg::KIND_LONG_ABS, branch_pkg::KIND_LONG_CALL:
        target = {byte1, byte2};
      branch_pkg::KIND_PAGE_JUMP, branch_pkg::KIND_PAGE_CALL:
        target = {next_pc[`ADDR_W-1:`PAGE_W],
                  opcode[`PAGE_HI_MSB:`PAGE_HI_LSB], byte1};
      branch_pkg::KIND_TABLE_JUMP:
        target = data_pointer_register + {8'h00, acc};
      default:
        target = next_pc;
    endcase
  end

endmodule // branch_target_calc

`default_nettype wire

// *** rtl/byte_compare.sv ***
// condition logic: accumulator zero test, decrement test, unsigned compare
// assumes operands were fetched by the core before the instruction starts
`default_nettype none

module byte_compare (
  // instruction class
  input  wire branch_pkg::instr_kind_t kind,
  // operands
  input  wire logic [7:0]              acc,
  input  wire logic [7:0]              first_byte,
  input  wire logic [7:0]              second_byte,
  // results
  output logic                         taken,
  output logic                         carry,
  output logic [7:0]                   dec_value
);

  // decision per class
  always_comb begin
    dec_value = first_byte - 8'h01;
    carry     = first_byte < second_byte;
    unique case (kind)
      branch_pkg::KIND_ACC_ZERO:    taken = (acc == 8'h00);
      branch_pkg::KIND_ACC_NONZERO: taken = (acc != 8'h00);
      branch_pkg::KIND_DEC_REG,
      branch_pkg::KIND_DEC_DIRECT:  taken = (dec_value != 8'h00);
      branch_pkg::KIND_COMPARE:     taken = (first_byte != second_byte);
      branch_pkg::KIND_NONE,
      branch_pkg::KIND_NO_OPERATION: taken = 1'b0;
      default:                      taken = 1'b1;
    endcase
  end

endmodule // byte_compare

`default_nettype wire

// *** rtl/branch_control_unit.sv ***
// program-flow unit: decodes jumps, calls, returns and branches, forms the
// next program counter, drives the return stack and the compare carry
// assumes the core supplies fetched bytes, operands and a one-cycle stack
`default_nettype none
`include "branch_params.svh"

// Operation
// - short relative jump: opcode plus one offset byte, reach -128..+127
// - long jump: opcode plus two bytes, full 16-bit target
// - in-page jump: opcode holds upper 3 of 11 bits, next byte low 8
// - in-page jump swaps low 11 pc bits, keeps upper 5
// - table jump loads pc with data pointer plus accumulator
// - long call takes a full 16-bit subroutine address
// - in-page call stays in the 2K block of the next instruction
// - subroutine return resumes after the entering call
// - interrupt return also signals completion if an interrupt was active at its start, else acts as plain return
// - all conditional jumps use a relative offset, -128..+127
// - no zero flag; zero tests look straight at the accumulator
// - decrement a byte, branch only when result nonzero
// - compare two bytes, branch only when they differ
// - compare is unsigned; carry set when first is below second
// - no-operation takes 1 us, every flow instruction 2 us
// - offset is signed, added to following address only when taken
module branch_control_unit #(
  parameter int unsigned MC_CLKS  = `MC_TIME_NS / `CLK_PERIOD_NS,
  parameter int unsigned NOP_MCS  = `NOP_TIME_NS / `MC_TIME_NS,
  parameter int unsigned FLOW_MCS = `FLOW_TIME_NS / `MC_TIME_NS
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // instruction from the fetch path
  input  wire logic                instr_valid,
  input  wire logic [7:0]          opcode,
  input  wire logic [7:0]          byte1,
  input  wire logic [7:0]          byte2,
  input  wire logic [`ADDR_W-1:0]  next_pc,
  // operands from accumulator and register file
  input  wire logic [7:0]          acc,
  input  wire logic [`ADDR_W-1:0]  data_pointer_register,
  input  wire logic [7:0]          first_byte,
  input  wire logic [7:0]          second_byte,
  // interrupt controller
  input  wire logic                intr_active,
  output logic                     intr_done,
  // stack
  output logic                     stack_push,
  output logic                     stack_pop,
  output logic [7:0]               stack_wdata,
  input  wire logic [7:0]          stack_rdata,
  // program counter
  output logic                     busy,
  output logic                     done,
  output logic                     pc_load,
  output logic [`ADDR_W-1:0]       pc_out,
  // status word carry and decremented byte
  output logic                     carry_we,
  output logic                     carry_out,
  output logic                     dec_we,
  output logic [7:0]               dec_out
);

  // refuse settings the counters cannot hold, and machine cycles too short for stack traffic
  if (MC_CLKS < 2 || MC_CLKS > (1 << `DIV_W)) begin : g_bad_div
    $error("MC_CLKS out of range");
  end
  if (NOP_MCS < 1 || FLOW_MCS < 1 || FLOW_MCS >= (1 << `MCS_W) ||
      NOP_MCS >= (1 << `MCS_W)) begin : g_bad_mcs
    $error("machine cycle counts out of range");
  end
  if (MC_CLKS < 8) begin : g_short_mc
    $error("MC_CLKS too small for stack traffic");
  end

  localparam logic [`DIV_W-1:0] DIV_LAST = `DIV_W'(MC_CLKS - 1);
  localparam logic [`MCS_W-1:0] NOP_LEN  = `MCS_W'(NOP_MCS);
  localparam logic [`MCS_W-1:0] FLOW_LEN = `MCS_W'(FLOW_MCS);

  branch_pkg::flow_reg_t     cur;
  branch_pkg::flow_reg_t     next_cur;
  branch_pkg::instr_kind_t   dec_kind;
  logic [`ADDR_W-1:0]        calc_target;
  logic                      cond_taken;
  logic                      cond_carry;
  logic [7:0]                cond_dec;
  logic                      mc_tick;

  // opcode classification
  function automatic branch_pkg::instr_kind_t decode_kind(input logic [7:0] op);
    branch_pkg::instr_kind_t k;
    k = branch_pkg::KIND_NONE;
    if (op == `OPC_NO_OPERATION)                         k = branch_pkg::KIND_NO_OPERATION;
    else if (op == `OPC_SHORT_JUMP)                      k = branch_pkg::KIND_SHORT_REL;
    else if (op == `OPC_LONG_JUMP)                       k = branch_pkg::KIND_LONG_ABS;
    else if (op == `OPC_LONG_CALL)                       k = branch_pkg::KIND_LONG_CALL;
    else if (op == `OPC_SUB_RETURN)                      k = branch_pkg::KIND_SUB_RETURN;
    else if (op == `OPC_INT_RETURN)                      k = branch_pkg::KIND_INT_RETURN;
    else if (op == `OPC_TABLE_JUMP)                      k = branch_pkg::KIND_TABLE_JUMP;
    else if (op == `OPC_JUMP_ACC_ZERO)                   k = branch_pkg::KIND_ACC_ZERO;
    else if (op == `OPC_JUMP_ACC_NZ)                     k = branch_pkg::KIND_ACC_NONZERO;
    else if (op == `OPC_DEC_DIRECT)                      k = branch_pkg::KIND_DEC_DIRECT;
    else if ((op & `REG_OPC_MASK) == `OPC_DEC_REG)       k = branch_pkg::KIND_DEC_REG;
    else if (op == `OPC_CMP_ACC_IMM || op == `OPC_CMP_ACC_DIR ||
             (op & `IND_OPC_MASK) == `OPC_CMP_IND ||
             (op & `REG_OPC_MASK) == `OPC_CMP_REG)      k = branch_pkg::KIND_COMPARE;
    else if ((op & `PAGE_OPC_MASK) == `OPC_PAGE_JUMP)    k = branch_pkg::KIND_PAGE_JUMP;
    else if ((op & `PAGE_OPC_MASK) == `OPC_PAGE_CALL)    k = branch_pkg::KIND_PAGE_CALL;
    return k;
  endfunction

  assign dec_kind = decode_kind(opcode);

  // destination address for the arriving instruction
  branch_target_calc u_target (
    .kind                  (dec_kind),
    .opcode                (opcode),
    .byte1                 (byte1),
    .byte2                 (byte2),
    .next_pc               (next_pc),
    .acc                   (acc),
    .data_pointer_register (data_pointer_register),
    .target                (calc_target)
  );

  // branch condition, carry and decrement for the arriving instruction
  byte_compare u_cond (
    .kind        (dec_kind),
    .acc         (acc),
    .first_byte  (first_byte),
    .second_byte (second_byte),
    .taken       (cond_taken),
    .carry       (cond_carry),
    .dec_value   (cond_dec)
  );

  // machine-cycle enable from the divider
  assign mc_tick = (cur.st != branch_pkg::ST_IDLE) && (cur.div == DIV_LAST);

  // next-state logic
  always_comb begin
    next_cur           = cur;
    next_cur.done      = 1'b0;
    next_cur.pc_load   = 1'b0;
    next_cur.push      = 1'b0;
    next_cur.pop       = 1'b0;
    next_cur.carry_we  = 1'b0;
    next_cur.dec_we    = 1'b0;
    next_cur.intr_done = 1'b0;

    // divider and machine-cycle countdown run while busy
    if (cur.st != branch_pkg::ST_IDLE) begin
      if (mc_tick) begin
        next_cur.div      = '0;
        next_cur.mcs_left = cur.mcs_left - `MCS_W'(1);
      end else begin
        next_cur.div = cur.div + `DIV_W'(1);
      end
    end

    unique case (cur.st)
      branch_pkg::ST_IDLE: begin
        if (instr_valid) begin
          next_cur.kind     = dec_kind;
          next_cur.target   = calc_target;
          next_cur.ret_addr = next_pc;
          next_cur.taken    = cond_taken;
          next_cur.carry    = cond_carry;
          next_cur.dec_val  = cond_dec;
          next_cur.in_intr  = intr_active;
          next_cur.div      = '0;
          next_cur.busy     = 1'b1;
          // length in machine cycles
          if (dec_kind == branch_pkg::KIND_NO_OPERATION || dec_kind == branch_pkg::KIND_NONE)
            next_cur.mcs_left = NOP_LEN;
          else
            next_cur.mcs_left = FLOW_LEN;
          unique case (dec_kind)
            branch_pkg::KIND_LONG_CALL, branch_pkg::KIND_PAGE_CALL:
              next_cur.st = branch_pkg::ST_PUSH_LO;
            branch_pkg::KIND_SUB_RETURN, branch_pkg::KIND_INT_RETURN:
              next_cur.st = branch_pkg::ST_POP_HI;
            default:
              next_cur.st = branch_pkg::ST_WAIT;
          endcase
        end
      end
      // return address onto the stack, low byte first
      branch_pkg::ST_PUSH_LO: begin
        next_cur.push  = 1'b1;
        next_cur.wdata = cur.ret_addr[7:0];
        next_cur.st    = branch_pkg::ST_PUSH_HI;
      end
      branch_pkg::ST_PUSH_HI: begin
        next_cur.push  = 1'b1;
        next_cur.wdata = cur.ret_addr[`ADDR_W-1:8];
        next_cur.st    = branch_pkg::ST_WAIT;
      end
      // two pops; data follows each pop by one cycle
      branch_pkg::ST_POP_HI: begin
        next_cur.pop = 1'b1;
        next_cur.st  = branch_pkg::ST_POP_LO;
      end
      branch_pkg::ST_POP_LO: begin
        next_cur.pop = 1'b1;
        next_cur.st  = branch_pkg::ST_CAP_HI;
      end
      branch_pkg::ST_CAP_HI: begin
        next_cur.target[`ADDR_W-1:8] = stack_rdata;
        next_cur.st                  = branch_pkg::ST_CAP_LO;
      end
      branch_pkg::ST_CAP_LO: begin
        next_cur.target[7:0] = stack_rdata;
        next_cur.st          = branch_pkg::ST_WAIT;
      end
      // hold until the last machine cycle ends, then retire
      branch_pkg::ST_WAIT: begin
        if (mc_tick && cur.mcs_left == `MCS_W'(1)) begin
          next_cur.st      = branch_pkg::ST_IDLE;
          next_cur.busy    = 1'b0;
          next_cur.done    = 1'b1;
          next_cur.pc_load = cur.taken;
          next_cur.pc_out  = cur.target;
          next_cur.carry_we  = (cur.kind == branch_pkg::KIND_COMPARE);
          next_cur.carry_out = cur.carry;
          next_cur.dec_we  = (cur.kind == branch_pkg::KIND_DEC_REG) ||
                             (cur.kind == branch_pkg::KIND_DEC_DIRECT);
          next_cur.dec_out = cur.dec_val;
          next_cur.intr_done = (cur.kind == branch_pkg::KIND_INT_RETURN) &&
                               cur.in_intr;
        end
      end
      default: next_cur.st = branch_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur <= '{st: branch_pkg::ST_IDLE, kind: branch_pkg::KIND_NONE, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state flops
  assign busy        = cur.busy;
  assign done        = cur.done;
  assign pc_load     = cur.pc_load;
  assign pc_out      = cur.pc_out;
  assign stack_push  = cur.push;
  assign stack_pop   = cur.pop;
  assign stack_wdata = cur.wdata;
  assign carry_we    = cur.carry_we;
  assign carry_out   = cur.carry_out;
  assign dec_we      = cur.dec_we;
  assign dec_out     = cur.dec_out;
  assign intr_done   = cur.intr_done;

endmodule // branch_control_unit

`default_nettype wire

// *** tb/stack_model.sv ***
// return stack model beside the program-flow unit
// one byte per push or pop; a popped byte shows for one cycle only
`default_nettype none

module stack_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // stack port
  input  wire logic       push,
  input  wire logic       pop,
  input  wire logic [7:0] wdata,
  output var  logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [16];
  logic [3:0] sp;

  // last in, first out; between pops the read line toggles so stale data never matches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp    <= 4'h0;
      rdata <= 8'h00;
    end else begin
      if (push) begin
        mem[sp] <= wdata;
        sp      <= sp + 4'h1;
      end
      if (pop) begin
        rdata <= mem[sp - 4'h1];
        sp    <= sp - 4'h1;
      end else begin
        rdata <= ~rdata;
      end
    end
  end
endmodule // stack_model

`default_nettype wire

// *** tb/branch_control_unit_asserts.sv ***
// checker for the program-flow unit: timing, stack order, results
// bound onto branch_control_unit; sees only its ports
`default_nettype none
`include "branch_params.svh"

module branch_control_unit_asserts #(
  parameter int unsigned MC_CLKS  = 200,
  parameter int unsigned NOP_MCS  = 1,
  parameter int unsigned FLOW_MCS = 2
) (
  // clock, reset, instruction
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               instr_valid,
  input wire logic [7:0]         opcode,
  input wire logic [7:0]         byte1,
  input wire logic [7:0]         byte2,
  input wire logic [`ADDR_W-1:0] next_pc,
  input wire logic [7:0]         first_byte,
  input wire logic [7:0]         second_byte,
  input wire logic               intr_active,
  // results
  input wire logic               intr_done,
  input wire logic               stack_push,
  input wire logic [7:0]         stack_wdata,
  input wire logic               busy,
  input wire logic               done,
  input wire logic               pc_load,
  input wire logic [`ADDR_W-1:0] pc_out,
  input wire logic               carry_we,
  input wire logic               carry_out,
  input wire logic               dec_we,
  input wire logic [7:0]         dec_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // cnt reads 1 just after the taking edge, so retirement shows length plus one
  localparam int FLOW_N = MC_CLKS * FLOW_MCS + 1;
  localparam int NOP_N  = MC_CLKS * NOP_MCS + 1;
  logic [15:0]        cnt;
  logic [7:0]         op_l, b1_l, b2_l, fb_l, sb_l;
  logic [`ADDR_W-1:0] npc_l;
  logic               ia_l;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // cycles since the taking edge, and the inputs seen there
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 16'h0000;
      {op_l, b1_l, b2_l, fb_l, sb_l, npc_l, ia_l} <= '0;
    end else if (instr_valid && !busy) begin
      cnt <= 16'h0001;
      {op_l, b1_l, b2_l, fb_l, sb_l} <= {opcode, byte1, byte2, first_byte, second_byte};
      {npc_l, ia_l} <= {next_pc, intr_active};
    end else if (busy) begin
      cnt <= cnt + 16'h0001;
    end
  end

  take_busy_a: assert property (instr_valid && !busy |=> busy)
    else $error("busy not raised after take");
  flow_time_a: assert property (pc_load |-> done && cnt == 16'(FLOW_N))
    else $error("flow instruction length wrong");
  done_time_a: assert property (done |-> !busy && (cnt == 16'(FLOW_N) || cnt == 16'(NOP_N)))
    else $error("done at wrong cycle");
  push_data_a: assert property (stack_push |->
      (cnt == 16'h0002 && stack_wdata == npc_l[7:0])
      || (cnt == 16'h0003 && stack_wdata == npc_l[15:8]))
    else $error("push byte or order wrong");
  push_pair_a: assert property (stack_push && cnt == 16'h0002 |=> stack_push)
    else $error("second push missing");
  long_jump_a: assert property (done && op_l == `OPC_LONG_JUMP |-> pc_load
      && pc_out == {b1_l, b2_l})
    else $error("long jump target wrong");
  intr_end_a: assert property (done || intr_done |-> done
      && intr_done == (op_l == `OPC_INT_RETURN && ia_l))
    else $error("interrupt completion wrong");
  carry_val_a: assert property (carry_we |-> done && carry_out == (fb_l < sb_l))
    else $error("compare carry wrong");
  cmp_take_a: assert property (carry_we |-> pc_load == (fb_l != sb_l))
    else $error("compare branch decision wrong");
  dec_take_a: assert property (dec_we |-> dec_out == fb_l - 8'h01
      && pc_load == (dec_out != 8'h00))
    else $error("decrement result or decision wrong");
endmodule // branch_control_unit_asserts

bind branch_control_unit branch_control_unit_asserts #(.MC_CLKS(MC_CLKS), .NOP_MCS(NOP_MCS),
  .FLOW_MCS(FLOW_MCS)) asserts_inst (.clk(clk), .rst(rst), .instr_valid(instr_valid),
  .opcode(opcode), .byte1(byte1), .byte2(byte2), .next_pc(next_pc), .first_byte(first_byte),
  .second_byte(second_byte), .intr_active(intr_active), .intr_done(intr_done),
  .stack_push(stack_push), .stack_wdata(stack_wdata), .busy(busy), .done(done),
  .pc_load(pc_load), .pc_out(pc_out), .carry_we(carry_we), .carry_out(carry_out),
  .dec_we(dec_we), .dec_out(dec_out));

`default_nettype wire

// *** tb/branch_control_unit_test.sv ***
// self-checking bench for the program-flow unit
// inputs change on the falling edge; stack_model answers pushes and pops
`default_nettype none
`include "branch_params.svh"

module branch_control_unit_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MC = 8;
  logic        clk, rst, instr_valid, intr_active, intr_done, stack_push, stack_pop;
  logic        busy, done, pc_load, carry_we, carry_out, dec_we;
  logic [7:0]  opcode, byte1, byte2, acc, first_byte, second_byte;
  logic [7:0]  stack_wdata, stack_rdata, dec_out;
  logic [15:0] next_pc, data_pointer_register, pc_out;
  int          errors, check_count, n, cyc;

  branch_control_unit #(.MC_CLKS(MC)) branch_control_unit_inst (.clk(clk), .rst(rst),
    .instr_valid(instr_valid), .opcode(opcode), .byte1(byte1), .byte2(byte2),
    .next_pc(next_pc), .acc(acc), .data_pointer_register(data_pointer_register),
    .first_byte(first_byte), .second_byte(second_byte), .intr_active(intr_active),
    .intr_done(intr_done), .stack_push(stack_push), .stack_pop(stack_pop),
    .stack_wdata(stack_wdata), .stack_rdata(stack_rdata), .busy(busy), .done(done),
    .pc_load(pc_load), .pc_out(pc_out), .carry_we(carry_we), .carry_out(carry_out),
    .dec_we(dec_we), .dec_out(dec_out));
  stack_model stack_model_inst (.clk(clk), .rst(rst), .push(stack_push), .pop(stack_pop),
    .wdata(stack_wdata), .rdata(stack_rdata));

  // 200 MHz clock and a cycle ceiling against hangs
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] rel(input logic [15:0] pc, input logic [7:0] o);
    return pc + {{8{o[7]}}, o};
  endfunction

  // one-cycle request, then wait for done; n ends as the done cycle
  task automatic go(input logic [7:0] op, b1, b2, input logic [15:0] pc);
    opcode = op;
    byte1 = b1;
    byte2 = b2;
    next_pc = pc;
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 40);
  endtask

  task automatic run(input logic [7:0] op, b1, b2, input logic [15:0] pc, input logic ld,
                     input logic [15:0] tgt);
    go(op, b1, b2, pc);
    chk(n, MC * 2, "cycles");
    chk(pc_load, ld, "pc_load");
    if (ld) chk(pc_out, tgt, "pc_out");
  endtask

  task automatic t_uncond();
    run(`OPC_SHORT_JUMP, 8'h80, 8'h00, 16'h0100, 1'b1, 16'h0080);
    run(`OPC_SHORT_JUMP, 8'h7F, 8'h00, 16'hFFF0, 1'b1, 16'h006F);
    run(`OPC_LONG_JUMP, 8'h12, 8'h34, 16'h0003, 1'b1, 16'h1234);
    run(8'hE1, 8'h5A, 8'h00, 16'hA7FF, 1'b1, 16'hA75A);
    acc = 8'h04;
    data_pointer_register = 16'hFFFE;
    run(`OPC_TABLE_JUMP, 8'h00, 8'h00, 16'h0001, 1'b1, 16'h0002);
  endtask

  task automatic t_calls();
    run(`OPC_LONG_CALL, 8'h20, 8'h00, 16'h1236, 1'b1, 16'h2000);
    run(8'h31, 8'h10, 8'h00, 16'h2002, 1'b1, 16'h2110);
    run(`OPC_SUB_RETURN, 8'h00, 8'h00, 16'h2111, 1'b1, 16'h2002);
    chk(intr_done, 1'b0, "intr_done");
    intr_active = 1'b1;
    run(`OPC_INT_RETURN, 8'h00, 8'h00, 16'h2003, 1'b1, 16'h1236);
    chk(intr_done, 1'b1, "intr_done");
    intr_active = 1'b0;
    run(`OPC_LONG_CALL, 8'h44, 8'h44, 16'h0810, 1'b1, 16'h4444);
    run(`OPC_INT_RETURN, 8'h00, 8'h00, 16'h4445, 1'b1, 16'h0810);
    chk(intr_done, 1'b0, "intr_done");
  endtask

  // zero and nonzero tests, each with a zero and a nonzero accumulator
  task automatic t_acc();
    for (int i = 0; i < 4; i++) begin
      acc = (i % 2) ? 8'hFF : 8'h00;
      run((i < 2) ? `OPC_JUMP_ACC_ZERO : `OPC_JUMP_ACC_NZ, 8'hF0, 8'h00, 16'h0200,
          (i < 2) == (acc == 8'h00), rel(16'h0200, 8'hF0));
    end
  endtask

  task automatic dec_case(input logic [7:0] op, fb, b1, b2, ofs);
    first_byte = fb;
    run(op, b1, b2, 16'h0300, fb != 8'h01, rel(16'h0300, ofs));
    chk(dec_we, 1'b1, "dec_we");
    chk(dec_out, 8'(fb - 8'h01), "dec_out");
  endtask

  task automatic t_dec();
    dec_case(8'hDF, 8'h01, 8'h10, 8'h00, 8'h10);
    dec_case(8'hD8, 8'h00, 8'h10, 8'h00, 8'h10);
    dec_case(`OPC_DEC_DIRECT, 8'h02, 8'h30, 8'h84, 8'h84);
  endtask

  task automatic cmp_case(input logic [7:0] op, fb, sb);
    first_byte = fb;
    second_byte = sb;
    run(op, 8'h00, 8'hFC, 16'h0400, fb != sb, rel(16'h0400, 8'hFC));
    chk(carry_we, 1'b1, "carry_we");
    chk(carry_out, fb < sb, "carry_out");
  endtask

  task automatic t_cmp();
    cmp_case(`OPC_CMP_ACC_IMM, 8'h05, 8'h06);
    cmp_case(`OPC_CMP_ACC_DIR, 8'h06, 8'h06);
    cmp_case(`OPC_CMP_IND, 8'hFF, 8'h01);
    cmp_case(8'hBF, 8'h00, 8'h80);
  endtask

  // no-operation and an unused opcode: one machine cycle, no side effects
  task automatic t_nop();
    go(`OPC_NO_OPERATION, 8'h00, 8'h00, 16'h0501);
    chk(n, MC, "nop cycles");
    chk(pc_load, 1'b0, "nop pc_load");
    go(8'hA5, 8'h00, 8'h00, 16'h0502);
    chk(n, MC, "unused cycles");
    chk({pc_load, carry_we, dec_we}, 3'h0, "unused strobes");
  endtask

  initial begin
    {instr_valid, intr_active, opcode, byte1, byte2, acc} = '0;
    {first_byte, second_byte, next_pc, data_pointer_register} = '0;
    {errors, check_count, cyc} = '0;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_uncond();
    t_calls();
    t_acc();
    t_dec();
    t_cmp();
    t_nop();
    give_verdict();
  end
endmodule // branch_control_unit_test

`default_nettype wire
